// >>> src/rsc_pkg.sv
// constants and types for the reset strap capture block
//
// Behaviour
// [RULE1] boot-hold strap 1 keeps boot application; 0 lets main application load.
// [RULE2] spread strap 0 disables spread-spectrum; 1 applies stored spread settings.
// [RULE3] while power-on reset is low, every strap pin stays undriven.
// [RULE4] each strap is sampled about 1.5 us after reset rises.
// [RULE5] a strap pin may become a debug output only after it was sampled.
// [RULE6] third strap is pulled high on the board and sampled like the others.
// [RULE7] spare test pins are open or pulled low and may serve as debug outputs.
// [RULE8] board ties production test enable to ground.
// [RULE9] reset rising starts self-configuration; low is reset, high is operation.
// [RULE10] captured strap values hold until the next power-on reset.
package rsc_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_PERIOD_PS     = 25000;   // 40 MHz reference
   localparam int unsigned SAMPLE_DELAY_PS   = 1500000; // 1.5 us after release
   localparam int unsigned SAMPLE_DELAY_CYC  =
      (SAMPLE_DELAY_PS / CLK_PERIOD_PS < 1) ? 1 : SAMPLE_DELAY_PS / CLK_PERIOD_PS;
   // ==========================================================
   // pin layout: three straps then five spare pins
   localparam int unsigned STRAP_COUNT       = 3;
   localparam int unsigned STRAP_BOOT_HOLD   = 0;
   localparam int unsigned STRAP_SPREAD      = 1;
   localparam int unsigned STRAP_THIRD       = 2;
   localparam int unsigned SPARE_COUNT       = 5;
   // ==========================================================
   // sequencer states, one-hot
   typedef enum logic [2:0] {
      RSC_ST_RESET = 3'h1,
      RSC_ST_WAIT  = 3'h2,
      RSC_ST_RUN   = 3'h4
   } rsc_state_type;
endpackage : rsc_pkg

// >>> src/rsc_strap_capture.sv
// reset strap capture: samples straps after power-on reset, then allows debug drive
module rsc_strap_capture
   import rsc_pkg::*;
#(
   parameter int unsigned DELAY_CYC = SAMPLE_DELAY_CYC
) (
   // clock and reset
   input  wire logic                   ref_clk_in,
   input  wire logic                   rst_in,
   // power-on reset pin, active low, synchronous to the clock
   input  wire logic                   power_on_reset_n_in,
   // strap pins: boot-hold, spread, third
   input  wire logic [STRAP_COUNT-1:0] strap_pin_in,
   output logic      [STRAP_COUNT-1:0] strap_pin_out,
   output logic      [STRAP_COUNT-1:0] strap_pin_oe_out,
   // spare test pins a..e
   output logic      [SPARE_COUNT-1:0] spare_test_pin_out,
   output logic      [SPARE_COUNT-1:0] spare_test_pin_oe_out,
   // debug drive request from the core
   input  wire logic                   debug_enable_in,
   input  wire logic [STRAP_COUNT-1:0] debug_strap_data_in,
   input  wire logic [SPARE_COUNT-1:0] debug_spare_data_in,
   // decoded configuration
   output logic                        stay_in_boot_out,
   output logic                        load_main_app_out,
   output logic                        spread_enable_out,
   output logic                        third_strap_out,
   output logic                        straps_valid_out,
   output logic                        config_start_out
);
   localparam int unsigned CW = $clog2(DELAY_CYC + 1);
   // one bit wider than the delay counter, so the delay check can saturate above it
   localparam int unsigned GW = CW + 1;

   // ==========================================================
   // elaboration checks
   // a zero delay would sample in the very edge that leaves reset
   if (DELAY_CYC < 1) begin : g_bad_delay
      $error("DELAY_CYC must be at least one");
   end
   // the decode below names three strap positions
   if (STRAP_COUNT < 3) begin : g_bad_straps
      $error("at least three strap pins are needed");
   end
   // the spare group is driven as one word
   if (SPARE_COUNT < 1) begin : g_bad_spares
      $error("at least one spare test pin is needed");
   end

   // ==========================================================
   // helpers
   // strap pad data: zero unless drive is allowed, so a stale word never leaks out
   function automatic logic [STRAP_COUNT-1:0] gate_strap(input logic en, input logic [STRAP_COUNT-1:0] data);
      gate_strap = en ? data : '0;
   endfunction : gate_strap

   // spare pad data, same gating as the straps
   function automatic logic [SPARE_COUNT-1:0] gate_spare(input logic en, input logic [SPARE_COUNT-1:0] data);
      gate_spare = en ? data : '0;
   endfunction : gate_spare

   // decode qualifier: a strap level counts only once the sequencer runs
   function automatic logic qualify(input logic run, input logic level);
      qualify = run && level;
   endfunction : qualify

   // ==========================================================
   // sequencer
   rsc_state_type   state;
   rsc_state_type   next_state;
   logic [CW-1:0]   count;
   logic [STRAP_COUNT-1:0] strap;
   wire  por_low    = ~power_on_reset_n_in;
   wire  count_done = (count == CW'(DELAY_CYC - 1));
   // [RULE4] sample timing
   wire  take       = (state == RSC_ST_WAIT) && count_done && !por_low;
   // [RULE5] drive only once sampled
   wire  drive_ok   = (state == RSC_ST_RUN) && debug_enable_in && !por_low;

   // next state; a low reset pin always returns to reset, even mid-wait
   always_comb begin
      next_state = state;
      case (state)
         RSC_ST_RESET: if (!por_low) next_state = RSC_ST_WAIT;   // [RULE9] rising edge starts
         RSC_ST_WAIT:  if (por_low) next_state = RSC_ST_RESET;
                       else if (count_done) next_state = RSC_ST_RUN;
         RSC_ST_RUN:   if (por_low) next_state = RSC_ST_RESET;
         default:      next_state = RSC_ST_RESET;
      endcase
   end

   // state and delay counter
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= RSC_ST_RESET;
         count <= '0;
      end else begin
         state <= next_state;
         count <= (next_state == RSC_ST_WAIT && state == RSC_ST_WAIT) ? count + CW'(1) : '0;
      end
   end

   // [RULE10] capture held until reset
   // [RULE6] third strap captured alike
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         strap <= '0;
      end else if (take) begin
         strap <= strap_pin_in;
      end
   end

   // ==========================================================
   // outputs, all registered; decode from the value being captured so it lines up with valid
   wire [STRAP_COUNT-1:0] next_strap = take ? strap_pin_in : strap;
   // decodes stay low until the run state, so the core never acts on a floating pad
   wire                   next_run        = (next_state == RSC_ST_RUN);
   // [RULE1] boot hold decode
   wire                   next_stay       = qualify(next_run, next_strap[STRAP_BOOT_HOLD]);
   wire                   next_load       = qualify(next_run, !next_strap[STRAP_BOOT_HOLD]);
   // [RULE2] spread decode
   wire                   next_spread     = qualify(next_run, next_strap[STRAP_SPREAD]);
   // [RULE6] third strap decode
   wire                   next_third      = qualify(next_run, next_strap[STRAP_THIRD]);
   // [RULE3] undriven during reset
   wire [STRAP_COUNT-1:0] next_strap_oe   = {STRAP_COUNT{drive_ok}};
   wire [STRAP_COUNT-1:0] next_strap_data = gate_strap(drive_ok, debug_strap_data_in);
   // [RULE7] spare pins as debug outputs
   wire [SPARE_COUNT-1:0] next_spare_oe   = {SPARE_COUNT{drive_ok}};
   wire [SPARE_COUNT-1:0] next_spare_data = gate_spare(drive_ok, debug_spare_data_in);

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stay_in_boot_out      <= 1'b0;
         load_main_app_out     <= 1'b0;
         spread_enable_out     <= 1'b0;
         third_strap_out       <= 1'b0;
         straps_valid_out      <= 1'b0;
         config_start_out      <= 1'b0;
         strap_pin_out         <= '0;
         strap_pin_oe_out      <= '0;
         spare_test_pin_out    <= '0;
         spare_test_pin_oe_out <= '0;
      end else begin
         // [RULE1] boot hold decode
         stay_in_boot_out      <= next_stay;
         load_main_app_out     <= next_load;
         // [RULE2] spread decode
         spread_enable_out     <= next_spread;
         third_strap_out       <= next_third;
         straps_valid_out      <= next_run;
         // [RULE9] one pulse on reset release
         config_start_out      <= (state == RSC_ST_RESET) && !por_low;
         // [RULE3] undriven during reset
         strap_pin_oe_out      <= next_strap_oe;
         strap_pin_out         <= next_strap_data;
         // [RULE7] spare pins as debug outputs
         spare_test_pin_oe_out <= next_spare_oe;
         spare_test_pin_out    <= next_spare_data;
      end
   end

   // ==========================================================
   // checks
   chk_no_drive_reset: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE3]
      $past(por_low) |-> strap_pin_oe_out == '0) else $error("strap pin driven during reset");
   chk_drive_after_sample: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE5]
      strap_pin_oe_out != '0 |-> straps_valid_out) else $error("strap pin driven before sample");
   // cycles seen since the start pulse, saturating; kept apart from the sequencer
   // so the delay check does not lean on the counter that it judges
   logic [GW-1:0] gap;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         gap <= '0;
      end else if (config_start_out) begin
         gap <= GW'(1);
      end else if (gap != '0 && gap != '1) begin
         gap <= gap + GW'(1);
      end
   end
   // [RULE4] sample delay count
   chk_sample_delay: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE4]
      $rose(straps_valid_out) |-> gap == GW'(DELAY_CYC)) else $error("sample delay wrong");
   chk_boot_decode: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE1]
      straps_valid_out |-> stay_in_boot_out != load_main_app_out) else $error("boot decode wrong");
   chk_hold_value: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE10]
      straps_valid_out && $past(straps_valid_out) |-> $stable(spread_enable_out) && $stable(stay_in_boot_out))
      else $error("captured strap changed");
   chk_spread_take: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE2]
      take |=> spread_enable_out == $past(strap_pin_in[STRAP_SPREAD])) else $error("spread decode wrong");
   chk_third_take: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE6]
      take |=> third_strap_out == $past(strap_pin_in[STRAP_THIRD])) else $error("third strap wrong");
   chk_spare_drive: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE7]
      spare_test_pin_oe_out != '0 |-> straps_valid_out) else $error("spare pin driven early");
   chk_start_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE9]
      config_start_out |=> !config_start_out) else $error("start not a pulse");
   // [RULE7] spare pins idle in reset
   chk_spare_reset: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE7]
      $past(por_low) |-> spare_test_pin_oe_out == '0) else $error("spare pin driven during reset");
   // [RULE1] decodes quiet until valid
   chk_decode_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE1]
      !straps_valid_out |-> !stay_in_boot_out && !load_main_app_out && !spread_enable_out && !third_strap_out)
      else $error("decode before capture");
   // [RULE9] low pin means reset
   chk_valid_drop: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE9]
      $past(por_low) |-> !straps_valid_out) else $error("valid kept during reset");
   // [RULE9] start only on release
   chk_start_release: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE9]
      config_start_out |-> !$past(por_low)) else $error("start without release");
   // [RULE1] boot strap taken as seen
   chk_boot_take: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE1]
      take |=> stay_in_boot_out == $past(strap_pin_in[STRAP_BOOT_HOLD])) else $error("boot strap wrong");
   // [RULE10] remaining decodes held
   chk_hold_rest: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE10]
      straps_valid_out && $past(straps_valid_out) |-> $stable(third_strap_out) && $stable(load_main_app_out))
      else $error("captured strap changed");
   // [RULE5] debug drive granted once sampled
   chk_debug_grant: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE5]
      straps_valid_out && debug_enable_in && !por_low |=> strap_pin_oe_out == '1 && spare_test_pin_oe_out == '1)
      else $error("debug drive not granted");
   // [RULE9] low pin in wait restarts
   chk_wait_restart: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE9]
      state == RSC_ST_WAIT && por_low |=> state == RSC_ST_RESET) else $error("wait not restarted");
endmodule : rsc_strap_capture

// >>> testbench/rsc_board_model.sv
// board pull resistors around the strap pads
module rsc_board_model
   import rsc_pkg::*;
(
   // pull choice per strap, 1 = pullup, and device drive
   input  wire logic [STRAP_COUNT-1:0] pull_up_in,
   input  wire logic [STRAP_COUNT-1:0] drive_in,
   input  wire logic [STRAP_COUNT-1:0] oe_in,
   output logic      [STRAP_COUNT-1:0] pad_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // third pulled up, others pull or drive; test enable grounded, no pin here
   assign pad_out = (oe_in & drive_in) | (~oe_in & (pull_up_in | 3'h4));
endmodule : rsc_board_model

// >>> testbench/tb.sv
// self-checking bench for the reset strap capture block
module tb;
   import rsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned DLY = 4;  // short delay keeps the run brief
   logic       ref_clk_in = 0, rst_in = 1, por_n = 0, dbg_en = 0;
   logic [2:0] pull = 0, pad, s_out, s_oe, dbg_s = 3'h5;
   logic [4:0] sp_out, sp_oe, dbg_p = 5'h15;
   logic       stay, load, spread, third, valid, start;
   int         failures = 0, cmp_count = 0, n, st;
   // rows: spread and boot pulls, then stay, load, spread
   logic [4:0] rows [4] = '{5'h02, 5'h0c, 5'h13, 5'h1d};
   always #12.5 ref_clk_in = ~ref_clk_in;
   rsc_strap_capture #(.DELAY_CYC(DLY)) dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .power_on_reset_n_in(por_n), .strap_pin_in(pad), .strap_pin_out(s_out), .strap_pin_oe_out(s_oe),
      .spare_test_pin_out(sp_out), .spare_test_pin_oe_out(sp_oe), .debug_enable_in(dbg_en),
      .debug_strap_data_in(dbg_s), .debug_spare_data_in(dbg_p), .stay_in_boot_out(stay),
      .load_main_app_out(load), .spread_enable_out(spread), .third_strap_out(third),
      .straps_valid_out(valid), .config_start_out(start));
   rsc_board_model board_u (.pull_up_in(pull), .drive_in(s_out), .oe_in(s_oe), .pad_out(pad));
   task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task end_sim;
      $display("checks %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // release the reset pin and count edges until valid, bounded
   task automatic release_wait;
      @(posedge ref_clk_in) por_n <= 1;
      n = 0;
      st = 0;
      while (valid !== 1'b1 && n < 50) begin
         @(posedge ref_clk_in);
         #1;
         n++;
         st += int'(start);
         // no drive before capture even with debug asked
         if (valid !== 1'b1) check("oe_early", {s_oe, sp_oe}, 16'h0000);
      end
      // a timeout counts here and fails the delay check as well, and the run goes on to the report
      if (n >= 50) failures++;
      check("delay", 16'(n), 16'(DLY + 1));
      check("start", 16'(st), 16'h0001);
   endtask : release_wait
   initial begin
      repeat (16) @(posedge ref_clk_in);
      check("oe_rst", {s_oe, sp_oe}, 16'h0000);
      rst_in <= 0;
      foreach (rows[i]) begin
         @(posedge ref_clk_in) por_n <= 0;
         pull <= {1'b0, rows[i][4:3]};
         dbg_en <= 1;
         dbg_s <= dbg_s + 3'h1;
         @(posedge ref_clk_in);
         #1 check("oe_por", {s_oe, sp_oe, valid}, 16'h0000);
         release_wait();
         check("decode", {third, stay, load, spread}, {1'b1, rows[i][2:0]});
         repeat (2) @(posedge ref_clk_in);
         #1 check("oe_dbg", {s_oe, sp_oe}, 16'h00ff);
         check("dbg_data", {s_out, sp_out}, {dbg_s, dbg_p});
         check("hold", {third, stay, load, spread}, {1'b1, rows[i][2:0]});
      end
      // reset pin dropped mid-wait restarts the capture
      @(posedge ref_clk_in) por_n <= 0;
      @(posedge ref_clk_in) por_n <= 1;
      repeat (2) @(posedge ref_clk_in);
      por_n <= 0;
      @(posedge ref_clk_in);
      #1 check("restart", {valid, s_oe}, 16'h0000);
      release_wait();
      check("decode2", {third, spread}, 16'h0003);
      // block reset in mid-run clears everything, then a fresh capture follows
      @(posedge ref_clk_in) rst_in <= 1;
      por_n <= 0;
      #1 check("rst_mid", {valid, stay, load, spread, s_oe}, 16'h0000);
      @(posedge ref_clk_in) rst_in <= 0;
      release_wait();
      check("decode3", {third, stay, load, spread}, 16'h000d);
      end_sim();
   end
endmodule : tb
